// ===== common/lss_pkg.sv
/*
 * Package for the linear sensor scan drive: state types, carrier structs and
 * timing constants. Assumes a 25 MHz core clock and a phase-clock domain
 * driven by the external driver.
 */
package lss_pkg;

	localparam int REF_CLK_MHZ = 25;
	localparam int PIXEL_COUNT_DEFAULT = 256;
	// Minimum high time of each phase and of the start pulse, in ns
	localparam int PHASE_HIGH_MIN_NS = 200;
	localparam int START_OVERLAP_MIN_NS = 200;
	// Integrator reset must not rise before this delay after phase 2 falls
	localparam int INT_RESET_DELAY_NS = 50;
	localparam int EDGE_GAP_BASE_NS = 20;
	localparam int INT_RESET_DELAY_CYC =
		(INT_RESET_DELAY_NS * REF_CLK_MHZ + 999) / 1000 < 1 ? 1 :
		(INT_RESET_DELAY_NS * REF_CLK_MHZ + 999) / 1000;
	localparam int PHASE_HIGH_MIN_CYC = (PHASE_HIGH_MIN_NS * REF_CLK_MHZ + 999) / 1000;
	localparam logic SCAN_DONE_IDLE = 1'b1;
	localparam logic [1:0] SYNC_RESET = 2'h0;

	typedef enum logic [1:0] {
		LSS_IDLE,
		LSS_ARMED,
		LSS_SCAN,
		LSS_DONE
	} lss_scan_e;

	// Pins from the external driver
	typedef struct packed {
		logic phase1;
		logic phase2;
		logic scan_start_pulse;
	} lss_drive_s;

	// Pixel-side outputs seen by the readout
	typedef struct packed {
		logic pixel_valid;
		logic [15:0] pixel_index;
		logic addr_switch_on;
		logic scan_done_pulse_n;
	} lss_video_s;

endpackage : lss_pkg

// ===== rtl/lss_scan_drive.sv
/*
 * Scan logic of a self-scanning linear photodiode array. The shift register
 * runs on the driver's phase-2 clock (link domain); a pixel index and the
 * end-of-scan event cross to ref_clk for the readout side, which also gets a
 * delayed integrator-reset permission. Assumes the driver keeps its phase
 * timing; phase overlaps are flagged, not corrected, and high times are not checked.
 * Assumes phase 2 runs much slower than ref_clk, so that every toggle of the
 * pixel handshake is seen by the two-stage synchroniser.
 * Assumes reset is held long enough for phase 2 to rise at least three times,
 * since the link side has no other clock with which to clear itself.
 * The end-of-scan pin is open drain: the data output is always low and the
 * enable pulls the line down for one phase-2 period.
 */
`timescale 1ns/1ps

module lss_scan_drive #(
	parameter int PIXEL_COUNT = lss_pkg::PIXEL_COUNT_DEFAULT
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic phase2_clk,
	input wire logic phase1,
	input wire logic scan_start_pulse,
	output logic addr_switch_on,
	output logic [15:0] pixel_index,
	output logic scan_done_pulse_o,
	output logic scan_done_pulse_oe,
	output logic pixel_strobe,
	output logic int_reset_allowed,
	output logic phase_overlap_err
);

	typedef struct packed {
		lss_pkg::lss_scan_e state;
		logic [15:0] index;
		logic switch_on;
		logic done_n;
		logic toggle;
		logic [1:0] rst_sync;
	} lss_link_s;

	typedef struct packed {
		logic [1:0] tog_sync;
		logic tog_last;
		logic [1:0] p1_sync;
		logic [1:0] p2_sync;
		logic p2_last;
		logic [7:0] gap_cnt;
		logic allowed;
		logic strobe;
		logic [15:0] index;
		logic switch_on;
		logic done_oe;
		logic overlap;
		logic [1:0] done_sync;
		logic done_o;
	} lss_core_s;

	lss_link_s link_reg;
	lss_link_s link_next;
	lss_core_s core_reg;
	lss_core_s core_next;

	// Two-stage synchroniser step: the new sample enters at the bottom
	function automatic logic [1:0] sync_step(input logic [1:0] stages, input logic sample);
		sync_step = {stages[0], sample};
	endfunction : sync_step

	// High for one sample when a synchronised level has just gone low
	function automatic logic fell(input logic last, input logic now);
		fell = last & ~now;
	endfunction : fell

	// Opens a scan at pixel zero and announces it across the domain boundary
	function automatic lss_link_s open_scan(input lss_link_s cur);
		open_scan = cur;
		open_scan.state = lss_pkg::LSS_SCAN;
		open_scan.index = 16'h0000;
		open_scan.switch_on = 1'b1;
		open_scan.toggle = ~cur.toggle;
	endfunction : open_scan

	// Start pulse is sampled on phase-2 edges only; a start that coincides
	// with phase 2 for the required overlap is therefore seen, except during a scan (LSS_SCAN), where it is ignored.
	always_comb begin
		link_next = link_reg;
		link_next.rst_sync = sync_step(link_reg.rst_sync, reset);
		link_next.done_n = lss_pkg::SCAN_DONE_IDLE;
		if (link_reg.rst_sync[1]) begin
			link_next.state = lss_pkg::LSS_IDLE;
			link_next.index = 16'h0000;
			link_next.switch_on = 1'b0;
			// A known toggle keeps the pixel strobe from going unknown
			link_next.toggle = 1'b0;
		end else begin
			case (link_reg.state)
				lss_pkg::LSS_IDLE: begin
					if (scan_start_pulse) begin
						link_next = open_scan(link_next);
					end
				end
				lss_pkg::LSS_ARMED: begin
					if (scan_start_pulse) begin
						link_next = open_scan(link_next);
					end else begin
						link_next.state = lss_pkg::LSS_IDLE;
					end
				end
				lss_pkg::LSS_SCAN: begin
					if (link_reg.index == 16'(PIXEL_COUNT - 1)) begin
						link_next.state = lss_pkg::LSS_DONE;
						link_next.switch_on = 1'b0;
						link_next.done_n = 1'b0;
					end else begin
						link_next.index = link_reg.index + 16'h0001;
						link_next.toggle = ~link_reg.toggle;
					end
				end
				lss_pkg::LSS_DONE: begin
					// A start seen here restarts at once, without an idle period
					if (scan_start_pulse) begin
						link_next = open_scan(link_next);
					end else begin
						link_next.state = lss_pkg::LSS_IDLE;
					end
				end
				default: begin
					link_next.state = lss_pkg::LSS_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge phase2_clk) begin
		link_reg <= link_next;
	end

	always_comb begin
		core_next = core_reg;
		core_next.tog_sync = sync_step(core_reg.tog_sync, link_reg.toggle);
		core_next.tog_last = core_reg.tog_sync[1];
		core_next.p1_sync = sync_step(core_reg.p1_sync, phase1);
		core_next.p2_sync = sync_step(core_reg.p2_sync, phase2_clk);
		core_next.p2_last = core_reg.p2_sync[1];
		core_next.done_sync = sync_step(core_reg.done_sync, ~link_reg.done_n);
		core_next.done_o = 1'b0;
		core_next.strobe = core_reg.tog_sync[1] ^ core_reg.tog_last;
		// Index and switch change together with the toggle and then stand for a whole phase
		// period, long after the synchronised toggle arrives, so they are taken without
		// synchronisers of their own; the toggle acts as their handshake.
		if (core_reg.strobe) begin
			core_next.index = link_reg.index;
			core_next.switch_on = link_reg.switch_on;
		end
		// Open drain: enable means pulling the line low
		core_next.done_oe = core_reg.done_sync[1];
		// No strobe follows the last pixel, so the end of scan closes the switch
		if (core_reg.done_sync[1]) begin
			core_next.switch_on = 1'b0;
		end
		// Reset permission opens a fixed delay after the synced phase-2 fall.
		// The synchroniser adds up to three cycles, which only errs on the late side.
		if (fell(core_reg.p2_last, core_reg.p2_sync[1])) begin
			core_next.gap_cnt = 8'h00;
			core_next.allowed = 1'b0;
		end else if (core_reg.gap_cnt != 8'(lss_pkg::INT_RESET_DELAY_CYC)) begin
			core_next.gap_cnt = core_reg.gap_cnt + 8'h01;
		end else begin
			core_next.allowed = 1'b1;
		end
		// Sampled check only: an overlap shorter than a ref_clk period can slip by
		if (core_reg.p1_sync[1] && core_reg.p2_sync[1]) begin
			core_next.overlap = 1'b1;
		end
		if (reset) begin
			core_next = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		core_reg <= core_next;
	end

	assign addr_switch_on = core_reg.switch_on;
	assign pixel_index = core_reg.index;
	assign scan_done_pulse_o = core_reg.done_o;
	assign scan_done_pulse_oe = core_reg.done_oe;
	assign pixel_strobe = core_reg.strobe;
	assign int_reset_allowed = core_reg.allowed;
	assign phase_overlap_err = core_reg.overlap;

endmodule : lss_scan_drive

// ===== dv/lss_scan_drive_chk.sv
/* Checker for the scan drive outputs. Assumes it is bound into lss_scan_drive. */
`timescale 1ns/1ps
module lss_scan_drive_chk #(
	parameter int PIXEL_COUNT = 4
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic addr_switch_on,
	input wire logic [15:0] pixel_index,
	input wire logic scan_done_pulse_o,
	input wire logic scan_done_pulse_oe,
	input wire logic pixel_strobe,
	input wire logic phase2_clk,
	input wire logic int_reset_allowed
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	chk_strobe_single: assert property (pixel_strobe |=> !pixel_strobe)
		else $error("pixel strobe wider than one cycle");
	chk_index_steps: assert property ($changed(pixel_index) && pixel_index != 16'h0 |->
		pixel_index == $past(pixel_index) + 16'h1)
		else $error("pixel index skipped");
	chk_done_last: assert property ($rose(scan_done_pulse_oe) |-> pixel_index == PIXEL_COUNT - 1)
		else $error("end of scan before last pixel");
	chk_done_low: assert property (scan_done_pulse_oe |-> !scan_done_pulse_o)
		else $error("end of scan not driven low");
	chk_switch_first: assert property ($rose(addr_switch_on) |-> pixel_index == 16'h0)
		else $error("scan did not open at pixel zero");
	chk_permit_delay: assert property ($rose(int_reset_allowed) |->
		!$past(phase2_clk, 2) && !$past(phase2_clk, 3))
		else $error("integrator reset permitted too soon");
endmodule : lss_scan_drive_chk

bind lss_scan_drive lss_scan_drive_chk #(.PIXEL_COUNT(PIXEL_COUNT)) chk_i (.ref_clk(ref_clk),
	.reset(reset), .addr_switch_on(addr_switch_on), .pixel_index(pixel_index),
	.scan_done_pulse_o(scan_done_pulse_o), .scan_done_pulse_oe(scan_done_pulse_oe),
	.pixel_strobe(pixel_strobe), .phase2_clk(phase2_clk),
	.int_reset_allowed(int_reset_allowed));

// ===== dv/lss_driver_model.sv
/* Phase clock driver model. Assumes run gates the clocks; they stand still when low. */
`timescale 1ns/1ps
module lss_driver_model #(
	parameter int PAUSE_NS = 200
) (
	input wire logic run,
	input wire logic start_req,
	output logic phase1,
	output logic phase2_clk,
	output logic scan_start_pulse
);
	initial begin
		{phase1, phase2_clk, scan_start_pulse} = 3'h0;
		forever if (run) begin
			// Gaps of 1 ns keep both phases from being high together
			#1 phase2_clk = 1'b1;
			#(PAUSE_NS) phase2_clk = 1'b0;
			// Start spans exactly one phase-2 pulse and fall
			#1 phase1 = 1'b1;
			scan_start_pulse = start_req;
			#(PAUSE_NS) phase1 = 1'b0;
		end else #5;
	end
endmodule : lss_driver_model

// ===== dv/lss_scan_drive_test.sv
/* Self-checking bench for the scan drive. Assumes the driver model above. */
`timescale 1ns/1ps
module lss_scan_drive_test;
	logic ref_clk = 1'b0, reset = 1'b1, run = 1'b1, start_req = 1'b0;
	logic phase1, phase2_clk, scan_start_pulse, addr_switch_on, oe, strobe, ov, perm;
	logic [15:0] pixel_index;
	int mismatches = 0, samples_checked = 0;
	always #20 ref_clk = ~ref_clk;
	lss_driver_model lss_driver_model_i (.run(run), .start_req(start_req), .phase1(phase1),
		.phase2_clk(phase2_clk), .scan_start_pulse(scan_start_pulse));
	lss_scan_drive #(.PIXEL_COUNT(4)) lss_scan_drive_i (.ref_clk(ref_clk), .reset(reset),
		.phase2_clk(phase2_clk), .phase1(phase1), .scan_start_pulse(scan_start_pulse),
		.addr_switch_on(addr_switch_on), .pixel_index(pixel_index), .scan_done_pulse_o(),
		.scan_done_pulse_oe(oe), .pixel_strobe(strobe), .int_reset_allowed(perm),
		.phase_overlap_err(ov));
	task check(input string what, input logic [15:0] exp, input logic [15:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask : check
	task complete_run;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run
	task scan_once;
		int n;
		n = 0;
		@(negedge ref_clk) start_req = 1'b1;
		while (!scan_start_pulse) @(negedge ref_clk);
		start_req = 1'b0;
		while (oe === 1'b1) @(negedge ref_clk);
		for (int i = 0; i < 400 && oe !== 1'b1; i++) begin
			if (strobe === 1'b1) n++;
			@(negedge ref_clk);
		end
		check("pixel strobes", 16'h4, 16'(n));
		check("last index", 16'h3, pixel_index);
		check("switch at end", 16'h0, {15'h0, addr_switch_on});
		check("overlap flag", 16'h0, {15'h0, ov});
		@(negedge phase2_clk);
		repeat (4) @(negedge ref_clk);
		check("reset permit early", 16'h0, {15'h0, perm});
		repeat (3) @(negedge ref_clk);
		check("reset permit", 16'h1, {15'h0, perm});
	endtask : scan_once
	initial begin
		repeat (16) @(negedge ref_clk);
		reset = 1'b0;
		repeat (3) @(posedge phase2_clk);
		scan_once();
		scan_once();
		complete_run();
	end
	initial begin
		#400000;
		mismatches++;
		complete_run();
	end
endmodule : lss_scan_drive_test
